/* iolc_pkg.sv */
// Purpose: Shared constants and carrier types for the I/O line controller upper registers.
// Assumes: 32 lines, APB slave with 8-bit byte address, 32-bit data.
// Notes:   Offsets are byte addresses, one aligned word each.
package iolc_pkg;
  localparam int unsigned LINES = 32;
  localparam int unsigned AW    = 8;

  localparam logic [7:0] OFS_IRQ_EN   = 8'h00;
  localparam logic [7:0] OFS_IRQ_DIS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_OD_EN    = 8'h10;
  localparam logic [7:0] OFS_OD_DIS   = 8'h14;
  localparam logic [7:0] OFS_OD_STATE = 8'h18;
  localparam logic [7:0] OFS_PU_DIS   = 8'h1c;
  localparam logic [7:0] OFS_PU_EN    = 8'h20;
  localparam logic [7:0] OFS_PU_STATE = 8'h24;
  localparam logic [7:0] OFS_FN_A     = 8'h28;
  localparam logic [7:0] OFS_FN_B     = 8'h2c;
  localparam logic [7:0] OFS_FN_STATE = 8'h30;
  localparam logic [7:0] OFS_DW_EN    = 8'h34;
  localparam logic [7:0] OFS_DW_DIS   = 8'h38;
  localparam logic [7:0] OFS_DW_STATE = 8'h3c;
  localparam logic [7:0] OFS_OUT_DATA = 8'h40;

  localparam logic [31:0] RST_MASK  = 32'h0000_0000;
  localparam logic [31:0] RST_STAT  = 32'h0000_0000;
  localparam logic [31:0] RST_OD    = 32'h0000_0000;
  localparam logic [31:0] RST_PU_DIS = 32'h0000_0000;
  localparam logic [31:0] RST_FN    = 32'h0000_0000;
  localparam logic [31:0] RST_DW    = 32'h0000_0000;
  localparam logic [31:0] RST_DATA  = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Output data and output enable of one peripheral function, per line.
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] oe;
  } iolc_fn_t;

  // Pad drive: level and active-low output enable, per line.
  typedef struct packed {
    logic [31:0] level;
    logic [31:0] oen;
  } iolc_pad_t;
endpackage

/* iolc_upper.sv */
// Purpose: Interrupt, open-drain, pull-up, function select and direct
//          write control for 32 I/O lines, with an APB register slave.
// Assumes: Single clock, synchronous active-high reset, zero wait APB.
// Notes:   Pin levels pass a three-stage synchroniser before use.
// Contract
// - Writing one to change_irq_enable enables that line's change interrupt.
// - Writing one to change_irq_disable disables that line's change interrupt.
// - change_irq_mask reads one for enabled lines, zero otherwise.
// - A detected level change sets the line's status bit.
// - Reading change_irq_status clears it; reset clears it too.
// - Writing one to open_drain_enable makes that line open-drain.
// - Writing one to open_drain_disable makes that line push-pull.
// - Open-drain lines are driven low only, never high.
// - Push-pull lines are driven high and low per output data.
// - Writing one to pullup_disable turns that line's pull-up off.
// - Writing one to pullup_enable turns that line's pull-up on.
// - pullup_state reads zero when pull-up on, one when off.
// - Writing one to func_a_select routes the line to function A.
// - Writing one to func_b_select routes the line to function B.
// - func_select_state reads zero for function A, one for B.
// - Writing one to direct_write_enable lets direct data writes reach that line.
// - Writing one to direct_write_disable blocks direct writes; zero does nothing.
// - direct_write_state reads one for lines following direct writes.
module iolc_upper (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  input  wire logic [31:0]       line_in_i,
  input  wire logic [31:0]       pio_owned_i,
  input  wire logic [31:0]       pio_oe_i,
  input  wire iolc_pkg::iolc_fn_t fn_a_i,
  input  wire iolc_pkg::iolc_fn_t fn_b_i,
  output iolc_pkg::iolc_pad_t    pad_o,
  output logic [31:0]            pullup_en_o,
  output logic [31:0]            line_level_o,
  output logic                   irq_o
);

  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;
  logic [31:0] sync3_ff;
  logic [31:0] level_ff;
  logic [31:0] nxt_level;
  logic [31:0] change;
  logic [31:0] mask_ff;
  logic [31:0] stat_ff;
  logic [31:0] od_ff;
  logic [31:0] pu_dis_ff;
  logic [31:0] fn_b_ff;
  logic [31:0] dw_ff;
  logic [31:0] data_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [31:0] rdata;
  logic        hit;
  logic        setup;
  logic        wr_acc;
  logic        stat_rd;
  logic [31:0] drv_data;
  logic [31:0] drv_en;

  // Zero wait states: every access phase completes at its first edge.
  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_ff;
  assign pslverr_o = pslverr_ff;
  assign setup     = psel_i & ~penable_i;
  assign wr_acc    = psel_i & penable_i & pwrite_i;
  assign stat_rd   = psel_i & penable_i & ~pwrite_i & ~pslverr_ff
                   & (paddr_i == iolc_pkg::OFS_IRQ_STAT);

  // Pin synchroniser; only the second and third stages are compared.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_ff <= iolc_pkg::ZERO_WORD;
      sync2_ff <= iolc_pkg::ZERO_WORD;
      sync3_ff <= iolc_pkg::ZERO_WORD;
    end else begin
      sync1_ff <= line_in_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A line's level moves only once two stages agree, which masks
  // the stage that may still be settling.
  always_comb begin
    nxt_level = (sync2_ff & ~(sync2_ff ^ sync3_ff))
              | (level_ff & (sync2_ff ^ sync3_ff));
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level_ff <= iolc_pkg::ZERO_WORD;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign change       = level_ff ^ nxt_level;
  assign line_level_o = level_ff;

  // Interrupt mask.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_ff <= iolc_pkg::RST_MASK;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_IRQ_EN) begin
      mask_ff <= mask_ff | pwdata_i;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_IRQ_DIS) begin
      mask_ff <= mask_ff & ~pwdata_i;
    end
  end

  // A read clears only the bits it returned, so a change landing
  // between setup and access is kept; a new change always wins.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stat_ff <= iolc_pkg::RST_STAT;
    end else if (stat_rd) begin
      stat_ff <= (stat_ff & ~prdata_ff) | change;
    end else begin
      stat_ff <= stat_ff | change;
    end
  end

  assign irq_o = |(stat_ff & mask_ff);

  // Open-drain selection.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      od_ff <= iolc_pkg::RST_OD;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_OD_EN) begin
      od_ff <= od_ff | pwdata_i;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_OD_DIS) begin
      od_ff <= od_ff & ~pwdata_i;
    end
  end

  // Pull-up control, held in its disabled sense to match its status.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pu_dis_ff <= iolc_pkg::RST_PU_DIS;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_PU_DIS) begin
      pu_dis_ff <= pu_dis_ff | pwdata_i;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_PU_EN) begin
      pu_dis_ff <= pu_dis_ff & ~pwdata_i;
    end
  end

  assign pullup_en_o = ~pu_dis_ff;

  // Peripheral function selection.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fn_b_ff <= iolc_pkg::RST_FN;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_FN_A) begin
      fn_b_ff <= fn_b_ff & ~pwdata_i;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_FN_B) begin
      fn_b_ff <= fn_b_ff | pwdata_i;
    end
  end

  // Direct output write permission.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dw_ff <= iolc_pkg::RST_DW;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_DW_EN) begin
      dw_ff <= dw_ff | pwdata_i;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_DW_DIS) begin
      dw_ff <= dw_ff & ~pwdata_i;
    end
  end

  // Output data; lines without permission ignore direct writes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_ff <= iolc_pkg::RST_DATA;
    end else if (wr_acc && paddr_i == iolc_pkg::OFS_OUT_DATA) begin
      data_ff <= (data_ff & ~dw_ff) | (pwdata_i & dw_ff);
    end
  end

  // Pad drive: controller data where it owns the line, else the
  // selected function.
  always_comb begin
    drv_data = (pio_owned_i & data_ff)
             | (~pio_owned_i & ~fn_b_ff & fn_a_i.data)
             | (~pio_owned_i & fn_b_ff & fn_b_i.data);
    drv_en   = (pio_owned_i & pio_oe_i)
             | (~pio_owned_i & ~fn_b_ff & fn_a_i.oe)
             | (~pio_owned_i & fn_b_ff & fn_b_i.oe);
  end

  // An open-drain line releases the pad instead of driving a one.
  assign pad_o.level = drv_data & ~od_ff;
  assign pad_o.oen   = ~(drv_en & (~od_ff | ~drv_data));

  // Read mux; reserved and write-only words read zero.
  always_comb begin
    hit   = 1'b1;
    rdata = iolc_pkg::ZERO_WORD;
    case (paddr_i)
      iolc_pkg::OFS_IRQ_EN:   rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_IRQ_DIS:  rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_IRQ_MASK: rdata = mask_ff;
      iolc_pkg::OFS_IRQ_STAT: rdata = stat_ff;
      iolc_pkg::OFS_OD_EN:    rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_OD_DIS:   rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_OD_STATE: rdata = od_ff;
      iolc_pkg::OFS_PU_DIS:   rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_PU_EN:    rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_PU_STATE: rdata = pu_dis_ff;
      iolc_pkg::OFS_FN_A:     rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_FN_B:     rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_FN_STATE: rdata = fn_b_ff;
      iolc_pkg::OFS_DW_EN:    rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_DW_DIS:   rdata = iolc_pkg::ZERO_WORD;
      iolc_pkg::OFS_DW_STATE: rdata = dw_ff;
      iolc_pkg::OFS_OUT_DATA: rdata = data_ff;
      default: begin
        hit   = 1'b0;
        rdata = iolc_pkg::ZERO_WORD;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle so that they
  // leave a flip-flop during the access phase.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_ff  <= iolc_pkg::ZERO_WORD;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff  <= pwrite_i ? iolc_pkg::ZERO_WORD : rdata;
      pslverr_ff <= ~hit;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_IRQ_EN: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_IRQ_EN
    |=> ((mask_ff & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("enable write did not set mask bits");

  AST_IRQ_DIS: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_IRQ_DIS
    |=> ((mask_ff & $past(pwdata_i)) == iolc_pkg::ZERO_WORD))
    else $error("disable write did not clear mask bits");

  AST_MASK_RD: assert property (
    setup && !pwrite_i && paddr_i == iolc_pkg::OFS_IRQ_MASK
    |=> prdata_o == $past(mask_ff) && !pslverr_o)
    else $error("mask read returned wrong value");

  AST_STAT_SET: assert property (
    (change != iolc_pkg::ZERO_WORD)
    |=> ((stat_ff & $past(change)) == $past(change)))
    else $error("change did not set status");

  AST_STAT_CLR: assert property (
    stat_rd ##0 (change == iolc_pkg::ZERO_WORD)
    |=> ((stat_ff & $past(prdata_ff)) == iolc_pkg::ZERO_WORD))
    else $error("status read did not clear bits");

  AST_OD_EN: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_OD_EN
    |=> ((od_ff & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("open-drain enable lost");

  AST_OD_DIS: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_OD_DIS
    |=> ((od_ff & $past(pwdata_i)) == iolc_pkg::ZERO_WORD))
    else $error("open-drain disable lost");

  AST_OD_LOW: assert property (
    (od_ff & ~pad_o.oen & pad_o.level) == iolc_pkg::ZERO_WORD)
    else $error("open-drain line driven high");

  AST_PP_DRV: assert property (
    ((~od_ff & drv_en & pad_o.oen) == iolc_pkg::ZERO_WORD)
    && ((~od_ff & (pad_o.level ^ drv_data)) == iolc_pkg::ZERO_WORD))
    else $error("push-pull line not driven to data");

  AST_PU_DIS: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_PU_DIS
    |=> ((pullup_en_o & $past(pwdata_i)) == iolc_pkg::ZERO_WORD))
    else $error("pull-up not turned off");

  AST_PU_EN: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_PU_EN
    |=> ((pullup_en_o & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("pull-up not turned on");

  AST_PU_RD: assert property (
    setup && !pwrite_i && paddr_i == iolc_pkg::OFS_PU_STATE
    |=> prdata_o == ~$past(pullup_en_o))
    else $error("pull-up status sense wrong");

  AST_FN_A: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_FN_A
    |=> ((fn_b_ff & $past(pwdata_i)) == iolc_pkg::ZERO_WORD))
    else $error("function A select lost");

  AST_FN_B: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_FN_B
    |=> ((fn_b_ff & $past(pwdata_i)) == $past(pwdata_i)))
    else $error("function B select lost");

  AST_FN_RD: assert property (
    setup && !pwrite_i && paddr_i == iolc_pkg::OFS_FN_STATE
    |=> prdata_o == $past(fn_b_ff))
    else $error("function status read wrong");

  AST_DW_WR: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_OUT_DATA
    |=> ((data_ff ^ $past(pwdata_i)) & $past(dw_ff)) == iolc_pkg::ZERO_WORD
        && ((data_ff ^ $past(data_ff)) & ~$past(dw_ff)) == iolc_pkg::ZERO_WORD)
    else $error("direct write permission not honoured");

  AST_DW_DIS: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_DW_DIS
    |=> dw_ff == ($past(dw_ff) & ~$past(pwdata_i)))
    else $error("write disable wrong");

  AST_DW_RD: assert property (
    setup && !pwrite_i && paddr_i == iolc_pkg::OFS_DW_STATE
    |=> prdata_o == $past(dw_ff))
    else $error("write status read wrong");

  AST_ZERO_KEEP: assert property (
    wr_acc && paddr_i == iolc_pkg::OFS_OD_EN
    |=> ((od_ff ^ $past(od_ff)) & ~$past(pwdata_i)) == iolc_pkg::ZERO_WORD)
    else $error("zero bit changed state");

  AST_IRQ_OUT: assert property (
    $rose(irq_o)
    |-> ($past(change & mask_ff) != iolc_pkg::ZERO_WORD)
        || $past(wr_acc && paddr_i == iolc_pkg::OFS_IRQ_EN))
    else $error("interrupt rose without a masked change");

  AST_CHANGE: assert property (
    (sync2_ff == sync3_ff) && (sync3_ff != level_ff)
    |=> level_ff == $past(sync3_ff)
        && ((stat_ff & $past(sync3_ff ^ level_ff)) != iolc_pkg::ZERO_WORD))
    else $error("agreed level change not taken");

endmodule

/* iolc_pins_model.sv */
// Purpose: Pins and the two peripheral functions on the far side of the controller.
// Assumes: One clock; the bench adds an external driver on each line.
// Notes:   A floating line without pull-up toggles every cycle, so no stale level hides.
module iolc_pins_model (
  input  wire logic                clk_i,
  input  wire iolc_pkg::iolc_pad_t pad_i,
  input  wire logic [31:0]         pullup_en_i,
  input  wire logic [31:0]         ext_en_i,
  input  wire logic [31:0]         ext_lvl_i,
  output logic [31:0]              line_o,
  output iolc_pkg::iolc_fn_t       fn_a_o,
  output iolc_pkg::iolc_fn_t       fn_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_ff = 1'b0;
  always_ff @(posedge clk_i) begin
    flip_ff <= ~flip_ff;
  end
  assign fn_a_o = {32'hffff_0000, 32'hffff_ffff};
  assign fn_b_o = {32'h0000_ffff, 32'hffff_ffff};
  // The controller's own drive wins over the external driver on a shared line.
  always_comb begin
    for (int n = 0; n < 32; n++) begin
      if (!pad_i.oen[n]) line_o[n] = pad_i.level[n];
      else if (ext_en_i[n]) line_o[n] = ext_lvl_i[n];
      else if (pullup_en_i[n]) line_o[n] = 1'b1;
      else line_o[n] = flip_ff;
    end
  end
endmodule

/* iolc_tb.sv */
// Purpose: Self-checking bench for the I/O line controller upper registers.
// Assumes: Zero-wait APB slave; pins come from the pin model.
// Notes:   Register rows run first, then interrupt, pad, refusal and reset cases.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } iolc_row_t;
  localparam iolc_row_t ROWS [11] = '{
    '{iolc_pkg::OFS_IRQ_EN,   32'hffff_0000, iolc_pkg::OFS_IRQ_MASK, 32'hffff_0000},
    '{iolc_pkg::OFS_IRQ_DIS,  32'h0f00_0000, iolc_pkg::OFS_IRQ_MASK, 32'hf0ff_0000},
    '{iolc_pkg::OFS_OD_EN,    32'h0000_00ff, iolc_pkg::OFS_OD_STATE, 32'h0000_00ff},
    '{iolc_pkg::OFS_OD_DIS,   32'h0000_000f, iolc_pkg::OFS_OD_STATE, 32'h0000_00f0},
    '{iolc_pkg::OFS_PU_DIS,   32'h0000_ff00, iolc_pkg::OFS_PU_STATE, 32'h0000_ff00},
    '{iolc_pkg::OFS_PU_EN,    32'h0000_0f00, iolc_pkg::OFS_PU_STATE, 32'h0000_f000},
    '{iolc_pkg::OFS_FN_B,     32'h00ff_0000, iolc_pkg::OFS_FN_STATE, 32'h00ff_0000},
    '{iolc_pkg::OFS_FN_A,     32'h000f_0000, iolc_pkg::OFS_FN_STATE, 32'h00f0_0000},
    '{iolc_pkg::OFS_DW_EN,    32'h0000_ffff, iolc_pkg::OFS_DW_STATE, 32'h0000_ffff},
    '{iolc_pkg::OFS_DW_DIS,   32'h0000_00ff, iolc_pkg::OFS_DW_STATE, 32'h0000_ff00},
    '{iolc_pkg::OFS_OUT_DATA, 32'hffff_ffff, iolc_pkg::OFS_OUT_DATA, 32'h0000_ff00}
  };
  logic clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, pio_owned_i = 32'hffff_ffff, pio_oe_i = 32'h0;
  logic [31:0] ext_en = 32'hffff_ffff, ext_lvl = 32'h0;
  logic        pready_o, pslverr_o, irq_o;
  logic [31:0] prdata_o, pullup_en_o, line_level_o, line_in_i, rd;
  logic        er;
  iolc_pkg::iolc_fn_t  fn_a_i, fn_b_i;
  iolc_pkg::iolc_pad_t pad_o;
  int n_errors = 0, n_compared = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  iolc_upper uut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .line_in_i(line_in_i),
    .pio_owned_i(pio_owned_i), .pio_oe_i(pio_oe_i), .fn_a_i(fn_a_i), .fn_b_i(fn_b_i),
    .pad_o(pad_o), .pullup_en_o(pullup_en_o), .line_level_o(line_level_o), .irq_o(irq_o));
  iolc_pins_model pins (.clk_i(clk_i), .pad_i(pad_o), .pullup_en_i(pullup_en_o),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .line_o(line_in_i), .fn_a_o(fn_a_i),
    .fn_b_o(fn_b_i));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, ex, got);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 100) n_errors++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, ROWS[i].wa, ROWS[i].wd);
      apb(1'b0, ROWS[i].ra, 32'h0);
      chk("row readback", ROWS[i].ex, rd);
    end
    $display("test register rows done");
    apb(1'b0, iolc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("quiet status", iolc_pkg::RST_STAT, rd);
    ext_lvl[31] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("irq masked line", 32'h1, {31'h0, irq_o});
    chk("line level", 32'h8000_0000, line_level_o);
    apb(1'b0, iolc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status line 31", 32'h8000_0000, rd);
    apb(1'b0, iolc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status cleared", 32'h0, rd);
    @(posedge clk_i);
    chk("irq after clear", 32'h0, {31'h0, irq_o});
    ext_lvl[8] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("irq unmasked line", 32'h0, {31'h0, irq_o});
    apb(1'b0, iolc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status line 8", 32'h0000_0100, rd);
    $display("test change interrupt done");
    pio_owned_i <= 32'hff00_ffff;
    pio_oe_i <= 32'h0000_00ff;
    apb(1'b1, iolc_pkg::OFS_DW_EN, 32'h0000_00ff);
    apb(1'b1, iolc_pkg::OFS_OUT_DATA, 32'h0000_00aa);
    @(posedge clk_i);
    chk("pad enables", 32'hff00_ffa0, pad_o.oen);
    chk("pad levels", 32'h000f_000a, pad_o.level & ~pad_o.oen);
    chk("pull-up out", 32'hffff_0fff, pullup_en_o);
    $display("test pad drive done");
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, 8'h02, 32'hffff_ffff);
    chk("misaligned err", 32'h1, {31'h0, er});
    apb(1'b0, iolc_pkg::OFS_IRQ_DIS, 32'h0);
    chk("write-only reads zero", 32'h0, rd);
    chk("write-only no error", 32'h0, {31'h0, er});
    $display("test refusals done");
    pio_owned_i <= 32'hffff_ffff;
    pio_oe_i <= 32'h0;
    ext_lvl <= 32'h0;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, ROWS[i].ra, 32'h0);
      chk("reset value", iolc_pkg::ZERO_WORD, rd);
    end
    apb(1'b0, iolc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("reset status", iolc_pkg::RST_STAT, rd);
    chk("reset irq", 32'h0, {31'h0, irq_o});
    $display("test reset done");
    report_and_stop();
  end
endmodule
